// ### rtl/cafi_pkg.sv
// cafi_pkg: register offsets, field positions and reset values of the CAN
// acceptance filter and interrupt block.
// assumes: one 40 MHz clock domain; registers reached over a plain strobe port.
package cafi_pkg;
    localparam int CAFI_CENTERS = 15;
    localparam int CAFI_AW      = 8;
    localparam int CAFI_DW      = 32;

    // ==================================================================
    // register map (word offsets on the plain port)
    // ==================================================================
    localparam logic [7:0] CAFI_OFS_CTRL      = 8'h00;  // controller_control_reg
    localparam logic [7:0] CAFI_OFS_STAT      = 8'h01;  // status / error events
    localparam logic [7:0] CAFI_OFS_GMASK     = 8'h02;  // global id mask, 29 bit
    localparam logic [7:0] CAFI_OFS_M15MASK   = 8'h03;  // center 15 id mask
    localparam logic [7:0] CAFI_OFS_MEDIA     = 8'h04;  // media arb [15:0], mask [31:16]
    localparam logic [7:0] CAFI_OFS_IRQFLAGS  = 8'h05;  // center_irq_flag, w1c
    localparam logic [7:0] CAFI_OFS_RXINFO    = 8'h06;  // last accepted frame
    localparam logic [7:0] CAFI_OFS_TXSEL     = 8'h07;  // transmit buffer pick
    localparam logic [7:0] CAFI_OFS_CCTRL     = 8'h10;  // center_control_reg, 1..15
    localparam logic [7:0] CAFI_OFS_CFMT      = 8'h20;  // center_format_reg, 1..15
    localparam logic [7:0] CAFI_OFS_CARB      = 8'h30;  // arbitration value, 1..15

    // ==================================================================
    // controller_control_reg fields
    // ==================================================================
    localparam int CAFI_CTRL_ERR_IE  = 0;   // error_irq_enable
    localparam int CAFI_CTRL_STAT_IE = 1;   // status_irq_enable
    localparam int CAFI_CTRL_GLB_IE  = 2;   // global_irq_enable
    localparam int CAFI_CTRL_CTL_IE  = 3;   // controller_irq_enable
    localparam int CAFI_STAT_ERR     = 0;
    localparam int CAFI_STAT_STS     = 1;

    // ==================================================================
    // center_control_reg fields
    // ==================================================================
    localparam int CAFI_CC_TX_IE = 0;       // tx_irq_enable
    localparam int CAFI_CC_RX_IE = 1;       // rx_irq_enable
    localparam int CAFI_CC_READY = 2;       // center_ready
    localparam int CAFI_CC_TXREQ = 3;       // message pending for transmit

    // ==================================================================
    // center_format_reg fields
    // ==================================================================
    localparam int CAFI_CF_MEDIA = 0;       // media_mask_enable
    localparam int CAFI_CF_IDMSK = 1;       // id_mask_enable
    localparam int CAFI_CF_EXT   = 2;       // id_format_select
    localparam int CAFI_CF_DIR   = 3;       // 1 = transmit
    localparam int CAFI_CF_DLC   = 4;       // data length, 4 bits
    localparam int CAFI_DLC_W    = 4;
    localparam logic [3:0] CAFI_DLC_MAX = 4'h8;

    localparam int CAFI_STD_W = 11;
    localparam int CAFI_EXT_W = 29;
    localparam logic [28:0] CAFI_STD_MASK = 29'h000007ff;
    localparam logic [28:0] CAFI_ALL_ONES = 29'h1fffffff;
    localparam logic [31:0] CAFI_ZERO32   = 32'h00000000;
    localparam logic [3:0]  CAFI_NONE     = 4'h0;
endpackage : cafi_pkg

// ### rtl/cafi_center_match.sv
// cafi_center_match: combinational acceptance test of one frame against one
// message center.
// assumes: all inputs stable in the cycle the verdict is taken.
`timescale 1ns/1ps
`default_nettype none
module cafi_center_match
    import cafi_pkg::*;
#(
    parameter bit IS_LAST = 1'b0
)
(
    input  wire logic [28:0] frame_id,
    input  wire logic        frame_ext,
    input  wire logic [15:0] frame_media,
    input  wire logic [28:0] arb_value,
    input  wire logic [28:0] own_mask,
    input  wire logic [28:0] global_mask,
    input  wire logic [15:0] media_arb,
    input  wire logic [15:0] media_mask,
    input  wire logic        id_format_select,
    input  wire logic        id_mask_enable,
    input  wire logic        media_mask_enable,
    output logic             pass
);
    logic [28:0] width_mask;
    logic [28:0] eff_mask;
    logic        id_ok;
    logic        media_ok;

    always_comb
    begin
        // 11 or 29 identifier bits take part
        width_mask = id_format_select ? CAFI_ALL_ONES : CAFI_STD_MASK;
        if (!id_mask_enable)
            eff_mask = width_mask;
        else if (IS_LAST)
            eff_mask = width_mask & own_mask & global_mask;
        else
            eff_mask = width_mask & global_mask;
        // a frame of the other format never matches
        id_ok    = (frame_ext == id_format_select)
                   && (((frame_id ^ arb_value) & eff_mask) == '0);
        media_ok = !media_mask_enable
                   || (((frame_media ^ media_arb) & media_mask) == '0);
        pass     = id_ok && media_ok;
    end
endmodule : cafi_center_match
`default_nettype wire

// ### rtl/cafi_regmem.sv
// cafi_regmem: per-center word memory (arbitration values) with a
// registered read port.
// assumes: single clock, one write and one read port.
`timescale 1ns/1ps
`default_nettype none
module cafi_regmem
#(
    parameter int DEPTH = 15,
    parameter int W     = 29
)
(
    input  wire logic                     mclk,
    input  wire logic                     arst_n,
    input  wire logic                     wr_en,
    input  wire logic [$clog2(DEPTH)-1:0] wr_idx,
    input  wire logic [W-1:0]             wr_data,
    input  wire logic [$clog2(DEPTH)-1:0] rd_idx,
    output logic      [W-1:0]             rd_data_q,
    output logic      [DEPTH*W-1:0]       all_q
);
    logic [W-1:0] mem_q [DEPTH];

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            for (int i = 0; i < DEPTH; i++)
                mem_q[i] <= '0;
        else if (wr_en && (int'(wr_idx) < DEPTH))
            mem_q[wr_idx] <= wr_data;
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            rd_data_q <= '0;
        else
            rd_data_q <= (int'(rd_idx) < DEPTH) ? mem_q[rd_idx] : '0;
    end

    always_comb
    begin
        for (int i = 0; i < DEPTH; i++)
            all_q[i*W +: W] = mem_q[i];
    end
endmodule : cafi_regmem
`default_nettype wire

// ### rtl/cafi_filter.sv
// cafi_filter: acceptance filtering of received frames over fifteen message
// centers, transmit buffer pick and one merged controller interrupt.
// assumes: the protocol engine delivers one frame per rx_valid pulse with
// its bit-error verdict; register port is a plain strobe slave.
// Function
// - one interrupt source from centers or errors
// - tx/rx success sets flag if enabled
// - only software clears center flag
// - all center flags ORed together
// - center irq needs global and controller enable
// - error/status irq gated by own enables
// - filter only frames free of bit errors
// - ready centers tested 1..15, first wins
// - three acceptance masks, optional enables
// - 11 or 29 id bits per format bit
// - format bit 1 selects masked compare
// - center 15 has own arbitration set
// - media byte test when format bit 0
// - load only if all enabled tests pass
// - direction bit picks transmit or receive
// - data length 0 to 8 bytes
// - center 15 receive only
// - reload tx buffer with lowest pending center
// - masked compare uses only mask ones
// - center 15 mask ANDed with global mask
// - media compare only where mask is one
`timescale 1ns/1ps
`default_nettype none
module cafi_filter
    import cafi_pkg::*;
#(
    parameter int NC = CAFI_CENTERS
)
(
    input  wire logic                 mclk,
    input  wire logic                 arst_n,
    // register port
    input  wire logic [CAFI_AW-1:0]   reg_addr,
    input  wire logic [CAFI_DW-1:0]   reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output logic      [CAFI_DW-1:0]   reg_rdata_q,
    // frames from the protocol engine
    input  wire logic                 rx_valid,
    input  wire logic                 rx_bit_error,
    input  wire logic [28:0]          rx_id,
    input  wire logic                 rx_ext,
    input  wire logic [15:0]          rx_media,
    // transmit side events
    input  wire logic                 tx_done,
    input  wire logic [3:0]           tx_done_center,
    input  wire logic                 tx_retry,
    input  wire logic                 err_event,
    input  wire logic                 stat_event,
    // outputs
    output logic                      rx_load_q,
    output logic      [3:0]           rx_load_center_q,
    output logic      [3:0]           tx_load_center_q,
    output logic                      can_irq_q
);
    // ==================================================================
    // registers
    // ==================================================================
    logic [3:0]          ctrl_q;
    logic [1:0]          stat_q;
    logic [28:0]         gmask_q;
    logic [28:0]         m15mask_q;
    logic [15:0]         media_arb_q;
    logic [15:0]         media_mask_q;
    logic [NC:1]         irq_flag_q;
    logic [3:0]          cctrl_q [1:NC];
    logic [7:0]          cfmt_q  [1:NC];
    logic [NC*29-1:0]    arb_all;
    logic [28:0]         arb_rd;
    logic [NC:1]         pass;
    logic [NC:1]         rx_ok;
    logic [3:0]          winner;
    logic [3:0]          tx_pick;
    logic                frame_go;
    logic                wr_center;
    logic [3:0]          cidx;
    logic                rd_arb_q;
    logic [CAFI_DW-1:0]  rd_mux;

    assign cidx      = reg_addr[3:0];
    assign wr_center = (cidx != CAFI_NONE);
    assign frame_go  = rx_valid && !rx_bit_error;

    // ==================================================================
    // per-center acceptance tests
    // ==================================================================
    // center 15 keeps its own arbitration set and mask
    genvar g;
    generate
        for (g = 1; g <= NC; g++)
        begin : g_center
            cafi_center_match #(
                .IS_LAST (g == NC)
            ) u_match (
                .frame_id          (rx_id),
                .frame_ext         (rx_ext),
                .frame_media       (rx_media),
                .arb_value         (arb_all[(g-1)*29 +: 29]),
                .own_mask          (m15mask_q),
                .global_mask       (gmask_q),
                .media_arb         (media_arb_q),
                .media_mask        (media_mask_q),
                .id_format_select  (cfmt_q[g][CAFI_CF_EXT]),
                .id_mask_enable    (cfmt_q[g][CAFI_CF_IDMSK]),
                .media_mask_enable (cfmt_q[g][CAFI_CF_MEDIA]),
                .pass              (pass[g])
            );
            // only ready receive centers take part
            assign rx_ok[g] = pass[g] && cctrl_q[g][CAFI_CC_READY]
                              && !cfmt_q[g][CAFI_CF_DIR];
        end
    endgenerate

    // lowest-numbered passing center wins
    always_comb
    begin
        winner = CAFI_NONE;
        for (int i = NC; i >= 1; i--)
            if (rx_ok[i])
                winner = 4'(i);
    end

    // lowest-numbered pending transmit center; 15 never transmits
    always_comb
    begin
        tx_pick = CAFI_NONE;
        for (int i = NC - 1; i >= 1; i--)
            if (cctrl_q[i][CAFI_CC_TXREQ] && cfmt_q[i][CAFI_CF_DIR]
                && cctrl_q[i][CAFI_CC_READY])
                tx_pick = 4'(i);
    end

    // ==================================================================
    // frame load result
    // ==================================================================
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rx_load_q        <= 1'b0;
            rx_load_center_q <= CAFI_NONE;
        end
        else
        begin
            // no winner: no load pulse, no flag, nothing touched
            rx_load_q        <= frame_go && (winner != CAFI_NONE);
            rx_load_center_q <= (frame_go && winner != CAFI_NONE) ? winner : rx_load_center_q;
        end
    end

    // transmit buffer reload after lost arbitration or error
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            tx_load_center_q <= CAFI_NONE;
        else if (tx_retry || tx_done || (tx_load_center_q == CAFI_NONE))
            tx_load_center_q <= tx_pick;
    end

    // ==================================================================
    // center interrupt flags
    // ==================================================================
    // set wins over a same-cycle software clear
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            irq_flag_q <= '0;
        else
            for (int i = 1; i <= NC; i++)
            begin
                if ((frame_go && winner == 4'(i) && cctrl_q[i][CAFI_CC_RX_IE])
                    || (tx_done && tx_done_center == 4'(i) && i != NC
                        && cctrl_q[i][CAFI_CC_TX_IE]))
                    irq_flag_q[i] <= 1'b1;
                else if (reg_wr && reg_addr == CAFI_OFS_IRQFLAGS && reg_wdata[i])
                    irq_flag_q[i] <= 1'b0;
            end
    end

    // error and status event flags, same set-over-clear policy
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            stat_q <= '0;
        else
        begin
            if (err_event)
                stat_q[CAFI_STAT_ERR] <= 1'b1;
            else if (reg_wr && reg_addr == CAFI_OFS_STAT && reg_wdata[CAFI_STAT_ERR])
                stat_q[CAFI_STAT_ERR] <= 1'b0;
            if (stat_event)
                stat_q[CAFI_STAT_STS] <= 1'b1;
            else if (reg_wr && reg_addr == CAFI_OFS_STAT && reg_wdata[CAFI_STAT_STS])
                stat_q[CAFI_STAT_STS] <= 1'b0;
        end
    end

    // one merged request toward the cpu
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            can_irq_q <= 1'b0;
        else
            can_irq_q <= ctrl_q[CAFI_CTRL_GLB_IE] && ctrl_q[CAFI_CTRL_CTL_IE]
                         && ((|irq_flag_q)
                             || (stat_q[CAFI_STAT_ERR] && ctrl_q[CAFI_CTRL_ERR_IE])
                             || (stat_q[CAFI_STAT_STS] && ctrl_q[CAFI_CTRL_STAT_IE]));
    end

    // ==================================================================
    // register writes
    // ==================================================================
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ctrl_q       <= '0;
            gmask_q      <= CAFI_ALL_ONES;
            m15mask_q    <= CAFI_ALL_ONES;
            media_arb_q  <= '0;
            media_mask_q <= '0;
        end
        else if (reg_wr)
            unique case (reg_addr)
                CAFI_OFS_CTRL:    ctrl_q       <= reg_wdata[3:0];
                CAFI_OFS_GMASK:   gmask_q      <= reg_wdata[28:0];
                CAFI_OFS_M15MASK: m15mask_q    <= reg_wdata[28:0];
                CAFI_OFS_MEDIA:
                begin
                    media_arb_q  <= reg_wdata[15:0];
                    media_mask_q <= reg_wdata[31:16];
                end
                default:          ;
            endcase
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            for (int i = 1; i <= NC; i++)
            begin
                cctrl_q[i] <= '0;
                cfmt_q[i]  <= '0;
            end
        else if (reg_wr && wr_center && int'(cidx) <= NC)
        begin
            if (reg_addr[7:4] == CAFI_OFS_CCTRL[7:4])
                cctrl_q[cidx] <= reg_wdata[3:0];
            if (reg_addr[7:4] == CAFI_OFS_CFMT[7:4])
            begin
                // direction forced to receive on center 15; length capped at 8
                cfmt_q[cidx][3:0] <= {reg_wdata[CAFI_CF_DIR] && int'(cidx) != NC,
                                      reg_wdata[2:0]};
                cfmt_q[cidx][7:4] <= (reg_wdata[7:4] > CAFI_DLC_MAX)
                                     ? CAFI_DLC_MAX : reg_wdata[7:4];
            end
        end
    end

    cafi_regmem #(
        .DEPTH (NC),
        .W     (29)
    ) u_arb (
        .mclk      (mclk),
        .arst_n    (arst_n),
        .wr_en     (reg_wr && reg_addr[7:4] == CAFI_OFS_CARB[7:4] && wr_center),
        .wr_idx    (cidx - 4'h1),
        .wr_data   (reg_wdata[28:0]),
        .rd_idx    (cidx - 4'h1),
        .rd_data_q (arb_rd),
        .all_q     (arb_all)
    );

    // ==================================================================
    // register reads, data one cycle after the strobe
    // ==================================================================
    always_comb
    begin
        rd_mux = CAFI_ZERO32;
        if (reg_addr == CAFI_OFS_CTRL)
            rd_mux = {28'h0000000, ctrl_q};
        else if (reg_addr == CAFI_OFS_STAT)
            rd_mux = {30'h00000000, stat_q};
        else if (reg_addr == CAFI_OFS_GMASK)
            rd_mux = {3'h0, gmask_q};
        else if (reg_addr == CAFI_OFS_M15MASK)
            rd_mux = {3'h0, m15mask_q};
        else if (reg_addr == CAFI_OFS_MEDIA)
            rd_mux = {media_mask_q, media_arb_q};
        else if (reg_addr == CAFI_OFS_IRQFLAGS)
            rd_mux = {16'h0000, irq_flag_q, 1'b0};
        else if (reg_addr == CAFI_OFS_RXINFO)
            rd_mux = {27'h0000000, rx_load_q, rx_load_center_q};
        else if (reg_addr == CAFI_OFS_TXSEL)
            rd_mux = {28'h0000000, tx_load_center_q};
        else if (wr_center && int'(cidx) <= NC
                 && reg_addr[7:4] == CAFI_OFS_CCTRL[7:4])
            rd_mux = {27'h0000000, irq_flag_q[cidx], cctrl_q[cidx]};
        else if (wr_center && int'(cidx) <= NC
                 && reg_addr[7:4] == CAFI_OFS_CFMT[7:4])
            rd_mux = {24'h000000, cfmt_q[cidx]};
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            rd_arb_q <= 1'b0;
        else
            rd_arb_q <= reg_rd && reg_addr[7:4] == CAFI_OFS_CARB[7:4] && wr_center;
    end

    // read data is rd_mux, registered; arbitration words are not in it
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            reg_rdata_q <= CAFI_ZERO32;
        else if (reg_rd)
            reg_rdata_q <= rd_mux;
        else
            reg_rdata_q <= CAFI_ZERO32;
    end

    // arbitration words are write only
    logic unused_ok;
    assign unused_ok = rd_arb_q & arb_rd[0];
endmodule : cafi_filter
`default_nettype wire

// ### tb/cafi_filter_assertions.sv
// checker for cafi_filter: port-level timing of accept, irq and reads.
// assumes: bound to every cafi_filter instance, one clock domain.
`timescale 1ns/1ps
`default_nettype none
module cafi_filter_chk
    import cafi_pkg::*;
#(
    parameter int NC = CAFI_CENTERS
)
(
    input wire logic        mclk,
    input wire logic        arst_n,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata_q,
    input wire logic        rx_valid,
    input wire logic        rx_bit_error,
    input wire logic        tx_done,
    input wire logic        err_event,
    input wire logic        stat_event,
    input wire logic        rx_load_q,
    input wire logic [3:0]  rx_load_center_q,
    input wire logic [3:0]  tx_load_center_q,
    input wire logic        can_irq_q
);
    logic [1:0] cause_q;
    logic [1:0] wr_q;
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cause_q <= 2'h0;
            wr_q    <= 2'h0;
        end
        else
        begin
            cause_q <= {cause_q[0], tx_done | err_event | stat_event | reg_wr | rx_load_q};
            wr_q    <= {wr_q[0], reg_wr};
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);
    sequence s_take; rx_valid && !rx_bit_error; endsequence
    sequence s_drop; rx_valid && rx_bit_error; endsequence
    AST_LOAD_CAUSE: assert property (rx_load_q |-> $past(rx_valid) && !$past(rx_bit_error))
        else $error("accept without a clean frame");
    AST_BITERR_DROP: assert property (s_drop |=> !rx_load_q)
        else $error("frame with bit error accepted");
    AST_WINNER: assert property (s_take ##1 rx_load_q |-> rx_load_center_q != 4'h0)
        else $error("accept names no center");
    AST_CENTER_HOLD: assert property (!rx_load_q |-> $stable(rx_load_center_q))
        else $error("winner changed without accept");
    AST_TX_NOT_LAST: assert property (tx_load_center_q != 4'hf)
        else $error("center 15 picked for transmit");
    AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata_q == 32'h0)
        else $error("read data outside read slot");
    AST_IRQ_SW_CLEAR: assert property ($fell(can_irq_q) |-> wr_q != 2'h0)
        else $error("irq dropped without host write");
    AST_IRQ_CAUSE: assert property ($rose(can_irq_q) |-> cause_q != 2'h0)
        else $error("irq raised without cause");
endmodule : cafi_filter_chk
bind cafi_filter cafi_filter_chk #(.NC(NC)) i_chk (.mclk(mclk), .arst_n(arst_n),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .rx_valid(rx_valid),
    .rx_bit_error(rx_bit_error), .tx_done(tx_done), .err_event(err_event),
    .stat_event(stat_event), .rx_load_q(rx_load_q), .rx_load_center_q(rx_load_center_q),
    .tx_load_center_q(tx_load_center_q), .can_irq_q(can_irq_q));
`default_nettype wire

// ### tb/cafi_can_node.sv
// cafi_can_node: stands for the bus side, hands one frame per fire.
// assumes: fire is a one-cycle command from the bench.
`timescale 1ns/1ps
`default_nettype none
module cafi_can_node
(
    input  wire logic        mclk,
    input  wire logic        arst_n,
    input  wire logic        fire,
    input  wire logic        bad,
    input  wire logic        ext,
    input  wire logic [28:0] id,
    input  wire logic [15:0] media,
    output logic             rx_valid,
    output logic             rx_bit_error,
    output logic             rx_ext,
    output logic      [28:0] rx_id,
    output logic      [15:0] rx_media
);
    // fields flip outside frames so stale values never match
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            {rx_valid, rx_bit_error, rx_ext, rx_id, rx_media} <= 47'h0;
        else
        begin
            rx_valid     <= fire;
            rx_bit_error <= fire ? bad : ~rx_bit_error;
            rx_ext       <= fire ? ext : ~rx_ext;
            rx_id        <= fire ? id : ~rx_id;
            rx_media     <= fire ? media : ~rx_media;
        end
    end
endmodule : cafi_can_node
`default_nettype wire

// ### tb/testbench.sv
// testbench: directed checks of acceptance order, masks and irq merging.
// assumes: cafi_filter register map as packaged, 40 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import cafi_pkg::*;
    logic mclk = 1'b0, arst_n = 1'b0, wr = 1'b0, rd = 1'b0, fire = 1'b0, ferr = 1'b0;
    logic fext = 1'b0, txd = 1'b0, txr = 1'b0, ee = 1'b0, se = 1'b0;
    logic [7:0]  a = 8'h00;
    logic [31:0] wd = 32'h0, rdq;
    logic [28:0] fid = 29'h0, rid;
    logic [15:0] fmed = 16'h0, rmed;
    logic [3:0]  txc = 4'h0, ldc, txl;
    logic        rv, rbe, rext, ld, irq;
    int          err_count = 0, n_tests = 0;
    always #12.5 mclk = ~mclk;
    cafi_can_node i_cafi_can_node (.mclk(mclk), .arst_n(arst_n), .fire(fire), .bad(ferr),
        .ext(fext), .id(fid), .media(fmed), .rx_valid(rv), .rx_bit_error(rbe),
        .rx_ext(rext), .rx_id(rid), .rx_media(rmed));
    cafi_filter i_cafi_filter (.mclk(mclk), .arst_n(arst_n), .reg_addr(a), .reg_wdata(wd),
        .reg_wr(wr), .reg_rd(rd), .reg_rdata_q(rdq), .rx_valid(rv), .rx_bit_error(rbe),
        .rx_id(rid), .rx_ext(rext), .rx_media(rmed), .tx_done(txd), .tx_done_center(txc),
        .tx_retry(txr), .err_event(ee), .stat_event(se), .rx_load_q(ld),
        .rx_load_center_q(ldc), .tx_load_center_q(txl), .can_irq_q(irq));
    task report_and_stop;
        $display("tests %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : report_and_stop
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            err_count++;
            $display("wrong value t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task w(input logic [7:0] ad, input logic [31:0] d);
        @(posedge mclk) {a, wd, wr} <= {ad, d, 1'b1};
        @(posedge mclk) wr <= 1'b0;
    endtask : w
    task r(input logic [7:0] ad, input logic [31:0] e);
        @(posedge mclk) {a, rd} <= {ad, 1'b1};
        @(posedge mclk) rd <= 1'b0;
        @(negedge mclk) chk(rdq, e);
    endtask : r
    task cfg(input logic [3:0] n, input logic [31:0] c, input logic [31:0] f, input logic [28:0] v);
        w(CAFI_OFS_CCTRL + 8'(n), c);
        w(CAFI_OFS_CFMT + 8'(n), f);
        w(CAFI_OFS_CARB + 8'(n), {3'h0, v});
    endtask : cfg
    task fr(input logic [28:0] id, input logic x, input logic [15:0] m, input logic b,
            input logic [3:0] e);
        @(posedge mclk) {fire, fid, fext, fmed, ferr} <= {1'b1, id, x, m, b};
        @(posedge mclk) fire <= 1'b0;
        @(posedge mclk);
        @(negedge mclk) chk({31'h0, ld}, {31'h0, e != 4'h0});
        if (e != 4'h0) chk({28'h0, ldc}, {28'h0, e});
    endtask : fr
    task settle(input logic e);
        repeat (2) @(posedge mclk);
        @(negedge mclk) chk({31'h0, irq}, {31'h0, e});
    endtask : settle
    task t_regs;
        r(CAFI_OFS_GMASK, 32'h1fffffff);
        r(CAFI_OFS_M15MASK, 32'h1fffffff);
        w(8'h08, 32'hffffffff);
        r(8'h08, 32'h0);
        w(CAFI_OFS_CFMT + 8'h1, 32'hf0);
        r(CAFI_OFS_CFMT + 8'h1, 32'h80);
        w(CAFI_OFS_CFMT + 8'hf, 32'h08);
        r(CAFI_OFS_CFMT + 8'hf, 32'h0);
        $display("test regs done");
    endtask : t_regs
    task t_order;
        cfg(4'h3, 32'h6, 32'h0, 29'h123);
        cfg(4'h5, 32'h6, 32'h0, 29'h123);
        fr(29'h123, 1'b0, 16'h0, 1'b0, 4'h3);
        fr(29'h123, 1'b0, 16'h0, 1'b1, 4'h0);
        fr(29'h124, 1'b0, 16'h0, 1'b0, 4'h0);
        fr(29'h123, 1'b1, 16'h0, 1'b0, 4'h0);
        r(CAFI_OFS_IRQFLAGS, 32'h8);
        chk({31'h0, irq}, 32'h0);
        w(CAFI_OFS_CTRL, 32'hc);
        settle(1'b1);
        w(CAFI_OFS_CCTRL + 8'h3, 32'h2);
        fr(29'h123, 1'b0, 16'h0, 1'b0, 4'h5);
        r(CAFI_OFS_CCTRL + 8'h5, 32'h16);
        w(CAFI_OFS_IRQFLAGS, 32'hffff);
        settle(1'b0);
        $display("test order done");
    endtask : t_order
    task t_mask;
        w(CAFI_OFS_GMASK, 32'h7f0);
        cfg(4'h2, 32'h6, 32'h2, 29'h120);
        fr(29'h12f, 1'b0, 16'h0, 1'b0, 4'h2);
        fr(29'h13f, 1'b0, 16'h0, 1'b0, 4'h0);
        cfg(4'hf, 32'h6, 32'h2, 29'h0a5);
        w(CAFI_OFS_M15MASK, 32'h0f0);
        fr(29'h7af, 1'b0, 16'h0, 1'b0, 4'hf);
        fr(29'h0b5, 1'b0, 16'h0, 1'b0, 4'h0);
        cfg(4'h4, 32'h6, 32'h1, 29'h055);
        w(CAFI_OFS_MEDIA, 32'h00ff0034);
        fr(29'h055, 1'b0, 16'hab34, 1'b0, 4'h4);
        fr(29'h055, 1'b0, 16'hab35, 1'b0, 4'h0);
        cfg(4'h6, 32'h6, 32'h4, 29'h1abcdef0);
        fr(29'h1abcdef0, 1'b1, 16'h0, 1'b0, 4'h6);
        fr(29'h0abcdef0, 1'b1, 16'h0, 1'b0, 4'h0);
        w(CAFI_OFS_IRQFLAGS, 32'hffff);
        $display("test mask done");
    endtask : t_mask
    task t_tx_err;
        cfg(4'h9, 32'hd, 32'h8, 29'h0);
        cfg(4'h7, 32'hd, 32'h8, 29'h0);
        @(posedge mclk) txr <= 1'b1;
        @(posedge mclk) txr <= 1'b0;
        @(negedge mclk) chk({28'h0, txl}, 32'h7);
        @(posedge mclk) {txd, txc} <= {1'b1, 4'h7};
        @(posedge mclk) txd <= 1'b0;
        r(CAFI_OFS_IRQFLAGS, 32'h80);
        w(CAFI_OFS_IRQFLAGS, 32'hffff);
        w(CAFI_OFS_CTRL, 32'hc);
        @(posedge mclk) {ee, se} <= 2'b11;
        @(posedge mclk) {ee, se} <= 2'b00;
        settle(1'b0);
        w(CAFI_OFS_CTRL, 32'hd);
        settle(1'b1);
        w(CAFI_OFS_STAT, 32'h3);
        settle(1'b0);
        $display("test tx and error done");
    endtask : t_tx_err
    initial
    begin
        repeat (3) @(posedge mclk);
        arst_n <= 1'b1;
        t_regs;
        t_order;
        t_mask;
        t_tx_err;
        report_and_stop;
    end
    initial
    begin
        repeat (5000) @(posedge mclk);
        err_count++;
        report_and_stop;
    end
endmodule : testbench
`default_nettype wire
